// >>> include/mrs_defines.vh
// Register map, field positions, reset values and timing constants of the reset sequencer.
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH

`define MRS_CLK_MHZ        40
`define MRS_CLK_PERIOD_NS  25
`define MRS_CNT_W          24

`define MRS_ADDR_CAUSE     3'h0
`define MRS_ADDR_IRQ_STAT  3'h1
`define MRS_ADDR_IRQ_EN    3'h2
`define MRS_ADDR_IRQ_CLR   3'h3
`define MRS_ADDR_CTRL      3'h4
`define MRS_ADDR_STATUS    3'h5

`define MRS_BIT_POR        0
`define MRS_BIT_EXT        1
`define MRS_BIT_DROP       2
`define MRS_BIT_WDOG       3
`define MRS_BIT_RELEASE    4
`define MRS_BIT_WD_SYSMODE 0

`define MRS_CAUSE_RESET    4'h0
`define MRS_IRQ_RESET      5'h00
`define MRS_CTRL_RESET     1'b1
`define MRS_POR_KEEP_MASK  4'h1

`define MRS_BOD_OFF        3'h7
`define MRS_BOD_LOW        3'h6
`define MRS_BOD_MID        3'h5
`define MRS_BOD_HIGH       3'h4

`define MRS_TOUT0_US       1000
`define MRS_TOUT1_US       4000
`define MRS_TOUT2_US       16000
`define MRS_TOUT3_US       64000
`define MRS_EXT_MIN_NS     2500
`define MRS_DROP_MIN_NS    2000

`endif

// >>> core/mrs_sync3.v
// Three-stage synchroniser whose output follows once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module mrs_sync3 (
  input  wire clk,
  input  wire reset_n,
  input  wire ce,
  input  wire rstVal,
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk) begin
    if (!reset_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else if (ce) begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end

  // The reset level input is left unused; every stage and the output reset to zero.
  wire unusedRst;
  assign unusedRst = rstVal;
endmodule
`default_nettype wire

// >>> core/mrs_pulse_filter.v
// Minimum-width filter: output rises only after the input has been active for MIN_CYC cycles.
`timescale 1ns/100ps
`default_nettype none
module mrs_pulse_filter #(
  parameter [15:0] MIN_CYC = 16'h0064
) (
  input  wire clk,
  input  wire reset_n,
  input  wire ce,
  input  wire active,
  output reg  qualified
);
  reg [15:0] cnt_reg;

  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg   <= 16'h0000;
      qualified <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        cnt_reg   <= 16'h0000;
        qualified <= 1'b0;
      end else if (cnt_reg >= MIN_CYC - 16'h0001) begin
        qualified <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/mrs_sequencer.v
// Reset source combiner, start-up delay counter and reset cause registers on Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "mrs_defines.vh"
module mrs_sequencer #(
  parameter [`MRS_CNT_W-1:0] TOUT0_CYC = `MRS_TOUT0_US * `MRS_CLK_MHZ,
  parameter [`MRS_CNT_W-1:0] TOUT1_CYC = `MRS_TOUT1_US * `MRS_CLK_MHZ,
  parameter [`MRS_CNT_W-1:0] TOUT2_CYC = `MRS_TOUT2_US * `MRS_CLK_MHZ,
  parameter [`MRS_CNT_W-1:0] TOUT3_CYC = `MRS_TOUT3_US * `MRS_CLK_MHZ,
  parameter [15:0] EXT_MIN_CYC  =
    (`MRS_EXT_MIN_NS + `MRS_CLK_PERIOD_NS - 1) / `MRS_CLK_PERIOD_NS,
  parameter [15:0] DROP_MIN_CYC =
    (`MRS_DROP_MIN_NS + `MRS_CLK_PERIOD_NS - 1) / `MRS_CLK_PERIOD_NS
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        ce,
  input  wire        supplyBelowPot,
  input  wire        extReset_n,
  input  wire        supplyBelowTrip,
  input  wire        watchdogExpire,
  input  wire [2:0]  brownoutLevelFuse,
  input  wire [1:0]  startupTimeSelectFuse,
  input  wire [3:0]  clockSourceSelectFuse,
  input  wire        extResetDisableFuse,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         ioPortInit,
  output reg         internalReset_n,
  output reg         fetchAtVector,
  output reg  [1:0]  dropTripSelect,
  output reg         irq
);
  localparam [1:0] ST_HOLD  = 2'h0;
  localparam [1:0] ST_COUNT = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;

  // Brown-out level decode; reserved codes leave the detector off.
  function [1:0] brownout_level_fuse;
    input [2:0] fuse;
    begin
      case (fuse)
        `MRS_BOD_LOW:  brownout_level_fuse = 2'h1;
        `MRS_BOD_MID:  brownout_level_fuse = 2'h2;
        `MRS_BOD_HIGH: brownout_level_fuse = 2'h3;
        default:       brownout_level_fuse = 2'h0;
      endcase
    end
  endfunction

  // Time-out choice; an external clock source needs no oscillator settling.
  function [`MRS_CNT_W-1:0] toutSel;
    input [1:0] startup_time_select_fuse;
    input [3:0] clock_source_select_fuse;
    begin
      if (clock_source_select_fuse == 4'h0) begin
        toutSel = TOUT0_CYC;
      end else begin
        case (startup_time_select_fuse)
          2'h0:    toutSel = TOUT0_CYC;
          2'h1:    toutSel = TOUT1_CYC;
          2'h2:    toutSel = TOUT2_CYC;
          default: toutSel = TOUT3_CYC;
        endcase
      end
    end
  endfunction

  wire [2:0] rawIn;
  wire [2:0] syncIn;
  wire       extLowQual;
  wire       dropQual;
  wire [3:0] srcVec;
  wire       anySrc;
  wire       asyncForce;
  wire       bodOn;

  assign rawIn = {supplyBelowTrip, ~extReset_n, supplyBelowPot};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gSync
      mrs_sync3 uSync (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .rstVal  (1'b0),
        .din     (rawIn[gi]),
        .dout    (syncIn[gi])
      );
    end
  endgenerate

  mrs_pulse_filter #(
    .MIN_CYC (EXT_MIN_CYC)
  ) uExtFilt (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .active    (syncIn[1]),
    .qualified (extLowQual)
  );

  mrs_pulse_filter #(
    .MIN_CYC (DROP_MIN_CYC)
  ) uDropFilt (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .active    (syncIn[2]),
    .qualified (dropQual)
  );

  reg        wdSysMode_reg;
  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [`MRS_CNT_W-1:0] cnt_reg;
  reg [`MRS_CNT_W-1:0] cnt_next;
  reg [`MRS_CNT_W-1:0] limit_reg;
  reg [`MRS_CNT_W-1:0] limit_next;
  reg [3:0]  srcPrev_reg;
  reg [3:0]  cause_reg;
  reg [3:0]  cause_next;
  reg [4:0]  irqStat_reg;
  reg [4:0]  irqStat_next;
  reg [4:0]  irqEn_reg;
  reg        releasePulse;

  assign bodOn = (brownout_level_fuse(brownoutLevelFuse) != 2'h0);
  assign srcVec[`MRS_BIT_POR]  = syncIn[0];
  assign srcVec[`MRS_BIT_EXT]  = extLowQual & ~extResetDisableFuse;
  assign srcVec[`MRS_BIT_DROP] = dropQual & bodOn;
  assign srcVec[`MRS_BIT_WDOG] = watchdogExpire & wdSysMode_reg;
  assign anySrc = |srcVec;

  // Raw pins bypass filtering here: ports must reach their safe state even without a clock.
  assign asyncForce = supplyBelowPot | (~extReset_n & ~extResetDisableFuse);

  always @* begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    limit_next   = limit_reg;
    releasePulse = 1'b0;
    case (state_reg)
      ST_HOLD: begin
        if (!anySrc) begin
          state_next = ST_COUNT;
          cnt_next   = {`MRS_CNT_W{1'b0}};
          limit_next = toutSel(startupTimeSelectFuse, clockSourceSelectFuse);
        end
      end
      ST_COUNT: begin
        if (anySrc) begin
          state_next = ST_HOLD;
          cnt_next   = {`MRS_CNT_W{1'b0}};
        end else if (cnt_reg >= limit_reg - {{(`MRS_CNT_W-1){1'b0}}, 1'b1}) begin
          state_next   = ST_RUN;
          releasePulse = 1'b1;
        end else begin
          cnt_next = cnt_reg + {{(`MRS_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_RUN: begin
        if (anySrc) begin
          state_next = ST_HOLD;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  // The asynchronous set only ever loads a constant; release follows the clocked sequencer.
  always @(posedge clk or posedge asyncForce) begin
    if (asyncForce) begin
      ioPortInit <= 1'b1;
    end else if (!reset_n) begin
      ioPortInit <= 1'b1;
    end else if (ce) begin
      ioPortInit <= (state_next != ST_RUN);
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state_reg       <= ST_HOLD;
      cnt_reg         <= {`MRS_CNT_W{1'b0}};
      limit_reg       <= {`MRS_CNT_W{1'b0}};
      srcPrev_reg     <= 4'h0;
      internalReset_n <= 1'b0;
      fetchAtVector   <= 1'b0;
      dropTripSelect  <= 2'h0;
    end else if (ce) begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      limit_reg       <= limit_next;
      srcPrev_reg     <= srcVec;
      internalReset_n <= (state_next == ST_RUN);
      fetchAtVector   <= releasePulse;
      dropTripSelect  <= brownout_level_fuse(brownoutLevelFuse);
    end
  end

  wire [3:0] srcRise;
  wire       wrTake;
  wire       wrLane0;
  assign srcRise = srcVec & ~srcPrev_reg;
  assign wrTake  = avs_write & ~avs_waitrequest;
  assign wrLane0 = wrTake & avs_byteenable[0];

  always @* begin
    cause_next = cause_reg;
    if (wrLane0 && avs_address[4:2] == `MRS_ADDR_CAUSE) begin
      cause_next = cause_next & avs_writedata[3:0];
    end
    if (srcVec[`MRS_BIT_POR]) begin
      cause_next = cause_next & `MRS_POR_KEEP_MASK;
    end
    cause_next = cause_next | srcVec;
    irqStat_next = irqStat_reg;
    if (wrLane0 && avs_address[4:2] == `MRS_ADDR_IRQ_CLR) begin
      irqStat_next = irqStat_next & ~avs_writedata[4:0];
    end
    irqStat_next = irqStat_next | {releasePulse, srcRise};
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      cause_reg       <= `MRS_CAUSE_RESET;
      irqStat_reg     <= `MRS_IRQ_RESET;
      irqEn_reg       <= `MRS_IRQ_RESET;
      wdSysMode_reg   <= `MRS_CTRL_RESET;
      irq             <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (ce) begin
      cause_reg   <= cause_next;
      irqStat_reg <= irqStat_next;
      irq         <= |(irqStat_reg & irqEn_reg);
      if (wrLane0 && avs_address[4:2] == `MRS_ADDR_IRQ_EN) begin
        irqEn_reg <= avs_writedata[4:0];
      end
      if (wrLane0 && avs_address[4:2] == `MRS_ADDR_CTRL) begin
        wdSysMode_reg <= avs_writedata[`MRS_BIT_WD_SYSMODE];
      end
      // One wait state: data is latched on the edge that drops waitrequest.
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end else if (avs_read || avs_write) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= 32'h00000000;
        if (avs_read) begin
          case (avs_address[4:2])
            `MRS_ADDR_CAUSE:    avs_readdata <= {28'h0000000, cause_reg};
            `MRS_ADDR_IRQ_STAT: avs_readdata <= {27'h0000000, irqStat_reg};
            `MRS_ADDR_IRQ_EN:   avs_readdata <= {27'h0000000, irqEn_reg};
            `MRS_ADDR_CTRL:     avs_readdata <= {31'h00000000, wdSysMode_reg};
            `MRS_ADDR_STATUS:   avs_readdata <= {26'h0000000, state_reg, srcVec};
            default:            avs_readdata <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/mrs_seq_properties.sv
// Port-level temporal checks of the reset sequencer, bound into its top module.
`timescale 1ns/100ps
`default_nettype none
module mrs_seq_properties #(
  parameter [23:0] TOUT0_CYC = 24'h000008
) (
  input wire        clk,
  input wire        reset_n,
  input wire        ce,
  input wire        supplyBelowPot,
  input wire        extReset_n,
  input wire        extResetDisableFuse,
  input wire [2:0]  brownoutLevelFuse,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  input wire        ioPortInit,
  input wire        internalReset_n,
  input wire        fetchAtVector,
  input wire [1:0]  dropTripSelect
);
  reg  [23:0] lowCnt;
  wire [1:0]  tripExp = brownoutLevelFuse == 3'h6 ? 2'h1 : brownoutLevelFuse == 3'h5 ? 2'h2 :
                        brownoutLevelFuse == 3'h4 ? 2'h3 : 2'h0;
  // The shortest time-out is the floor for any release, whatever the fuses select.
  always @(posedge clk) begin
    if (!reset_n || internalReset_n)
      lowCnt <= 24'h000000;
    else
      lowCnt <= lowCnt + 24'h000001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=>
    !avs_waitrequest) else $error("bus answer missing");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  fetch_release_a: assert property (fetchAtVector |-> $rose(internalReset_n))
    else $error("fetch without release");
  release_fetch_a: assert property ($rose(internalReset_n) |-> fetchAtVector)
    else $error("release without fetch");
  por_ports_a: assert property (supplyBelowPot |-> ioPortInit)
    else $error("ports not forced by low supply");
  pin_ports_a: assert property (!extReset_n && !extResetDisableFuse |-> ioPortInit)
    else $error("ports not forced by pin");
  por_reset_a: assert property (supplyBelowPot |-> ##[0:6] !internalReset_n)
    else $error("low supply did not reset");
  stretch_min_a: assert property ($rose(internalReset_n) |-> lowCnt >= TOUT0_CYC)
    else $error("reset released too early");
  trip_code_a: assert property ($past(reset_n) |-> dropTripSelect == tripExp)
    else $error("trip level decode wrong");
  cover property ($rose(internalReset_n));
  cover property (!avs_waitrequest && avs_read);
  cover property (supplyBelowPot ##1 !supplyBelowPot);
endmodule
bind mrs_sequencer mrs_seq_properties #(.TOUT0_CYC(TOUT0_CYC)) chk_i (.*);
`default_nettype wire

// >>> bench/mrs_source_model.sv
// Behavioural supply monitors, board reset pin and watchdog feeding the sequencer.
`timescale 1ns/100ps
`default_nettype none
module mrs_source_model (
  input  wire       clk,
  input  wire [3:0] req,
  output reg        supplyBelowPot = 1'b1,
  output reg        extReset_n = 1'b1,
  output reg        supplyBelowTrip = 1'b0,
  output reg        watchdogExpire = 1'b0
);
  reg wdogLast = 1'b0;
  // Expiry is a single-cycle pulse however long the request is held.
  always @(posedge clk) begin
    supplyBelowPot <= req[0];
    extReset_n <= !req[1];
    supplyBelowTrip <= req[2];
    watchdogExpire <= req[3] && !wdogLast;
    wdogLast <= req[3];
  end
endmodule
`default_nettype wire

// >>> bench/test_mcu_reset_source_sequencer.sv
// Directed test of the reset sequencer through its sources and registers.
`timescale 1ns/100ps
`default_nettype none
module test_mcu_reset_source_sequencer;
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [3:0]  req = 4'h1;
  reg  [4:0]  adr = 5'h00;
  reg         rdS = 1'b0;
  reg         wrS = 1'b0;
  reg  [31:0] wdat = 32'h00000000;
  reg  [3:0]  be = 4'hF;
  reg  [31:0] q;
  integer     mismatches = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     n;
  integer     m;
  reg         ceS = 1'b1;
  reg  [2:0]  bodF = 3'h6;
  reg  [1:0]  sutF = 2'h1;
  reg  [3:0]  ckF = 4'h1;
  reg         disF = 1'b0;
  localparam [23:0] T0 = 24'h000008;
  localparam [23:0] T1 = 24'h00000C;
  localparam [23:0] T2 = 24'h000010;
  localparam [23:0] T3 = 24'h000014;
  localparam [15:0] MINW = 16'h0004;
  wire        por, pin_n, drop, wdog, waitReq, ioInit, intRst_n, fetch, irq;
  wire [31:0] rdat;
  wire [1:0]  trip;
  initial forever #12.5 clk = ~clk;
  mrs_source_model src (.clk(clk), .req(req), .supplyBelowPot(por), .extReset_n(pin_n),
    .supplyBelowTrip(drop), .watchdogExpire(wdog));
  mrs_sequencer #(.TOUT0_CYC(T0), .TOUT1_CYC(T1), .TOUT2_CYC(T2),
    .TOUT3_CYC(T3), .EXT_MIN_CYC(MINW), .DROP_MIN_CYC(MINW)) dut (
    .clk(clk), .reset_n(reset_n), .ce(ceS), .supplyBelowPot(por), .extReset_n(pin_n),
    .supplyBelowTrip(drop), .watchdogExpire(wdog), .brownoutLevelFuse(bodF),
    .startupTimeSelectFuse(sutF), .clockSourceSelectFuse(ckF), .extResetDisableFuse(disF),
    .avs_address(adr), .avs_read(rdS), .avs_write(wrS), .avs_writedata(wdat),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(waitReq),
    .ioPortInit(ioInit), .internalReset_n(intRst_n), .fetchAtVector(fetch),
    .dropTripSelect(trip), .irq(irq));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [8*10-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("unexpected %0s exp %0h got %0h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [4:0] a, input [31:0] d, input [3:0] b);
    begin
      adr <= a;
      wrS <= w;
      rdS <= !w;
      wdat <= d;
      be <= b;
      @(posedge clk);
      while (waitReq !== 1'b0) @(posedge clk);
      q = rdat;
      wrS <= 1'b0;
      rdS <= 1'b0;
      @(posedge clk);
    end
  endtask
  task hold(input integer i, input integer c);
    begin
      req[i] <= 1'b1;
      repeat (c) @(posedge clk);
      req[i] <= 1'b0;
      @(posedge clk);
    end
  endtask
  task waitRst(input v);
    begin
      n = 0;
      while (intRst_n !== v) begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask
  // Release must take at least the selected time-out of 12 cycles, plus synchroniser lag.
  task rel;
    begin
      waitRst(1'b1);
      chk("delay", 32'h1, {31'h0, n >= 12 && n <= 30});
    end
  endtask
  task cause(input [31:0] e);
    begin
      bus(1'b0, 5'h00, 32'h0, 4'hF);
      chk("cause", e, q);
      bus(1'b1, 5'h00, 32'h0, 4'hF);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("ports", 32'h1, ioInit);
    chk("intrst", 32'h0, intRst_n);
    req[0] <= 1'b0;
    rel;
    chk("fetch", 32'h1, fetch);
    cause(32'h1);
    cause(32'h0);
    bus(1'b0, 5'h04, 32'h0, 4'hF);
    chk("irqstat", 32'h10, q & 32'h10);
    chk("irqmask", 32'h0, irq);
    bus(1'b1, 5'h08, 32'h10, 4'hF);
    repeat (2) @(posedge clk);
    chk("irqon", 32'h1, irq);
    bus(1'b1, 5'h0C, 32'h10, 4'hF);
    repeat (2) @(posedge clk);
    chk("irqoff", 32'h0, irq);
    bus(1'b0, 5'h18, 32'h0, 4'hF);
    chk("unmapped", 32'h0, q);
    hold(1, 2);
    repeat (12) @(posedge clk);
    chk("shortpin", 32'h1, intRst_n);
    hold(1, 12);
    repeat (6) @(posedge clk);
    hold(1, 12);
    rel;
    cause(32'h2);
    bus(1'b1, 5'h10, 32'h0, 4'h0);
    hold(3, 1);
    waitRst(1'b0);
    rel;
    cause(32'h8);
    bus(1'b1, 5'h10, 32'h0, 4'hF);
    hold(3, 1);
    repeat (8) @(posedge clk);
    chk("wdogoff", 32'h1, intRst_n);
    chk("trip", 32'h1, trip);
    hold(2, 2);
    repeat (12) @(posedge clk);
    chk("shortdip", 32'h1, intRst_n);
    hold(2, 12);
    rel;
    bus(1'b0, 5'h00, 32'h0, 4'hF);
    chk("cause", 32'h4, q);
    req[0] <= 1'b1;
    @(posedge clk);
    #2 chk("ports", 32'h1, ioInit);
    @(posedge clk);
    repeat (6) @(posedge clk);
    chk("intrst", 32'h0, intRst_n);
    req[0] <= 1'b0;
    rel;
    cause(32'h1);
    disF <= 1'b1;
    hold(1, 12);
    repeat (12) @(posedge clk);
    chk("pindis", 32'h1, intRst_n);
    disF <= 1'b0;
    hold(1, 12);
    waitRst(1'b1);
    m = n;
    ckF <= 4'h0;
    hold(1, 12);
    waitRst(1'b1);
    chk("tout0", T1 - T0, m - n);
    ceS <= 1'b0;
    hold(1, 12);
    repeat (4) @(posedge clk);
    chk("freeze", 32'h1, intRst_n);
    ceS <= 1'b1;
    repeat (4) @(posedge clk);
    chk("thaw", 32'h1, intRst_n);
    test_done;
  end
endmodule
`default_nettype wire
